// ==== pkg/ntp_cfg_pkg.sv ====
package ntp_cfg_pkg;
   // ***************************************************
   // register offsets
   // ***************************************************
   localparam logic [15:0] OFS_BCAST  = 16'h0020;
   localparam logic [15:0] OFS_COMMIT = 16'h0080;
   localparam logic [15:0] OFS_MODE   = 16'h0084;
   localparam logic [15:0] OFS_VLAN   = 16'h0088;
   localparam logic [15:0] OFS_MAC_LO = 16'h008c;
   localparam logic [15:0] OFS_MAC_HI = 16'h0090;
   localparam logic [15:0] OFS_IP0    = 16'h0094;
   localparam logic [15:0] OFS_IP1    = 16'h0098;
   localparam logic [15:0] OFS_IP2    = 16'h009c;
   localparam logic [15:0] OFS_IP3    = 16'h00a0;
   localparam logic [15:0] OFS_REFID  = 16'h00a4;
   localparam logic [15:0] OFS_UTC_CT = 16'h0100;
   localparam logic [15:0] OFS_UTC    = 16'h0104;
   // ***************************************************
   // field positions, masks and codes
   // ***************************************************
   localparam int B_MODE_V = 0;
   localparam int B_VLAN_V = 1;
   localparam int B_MAC_V  = 2;
   localparam int B_IP_V   = 3;
   localparam int B_REF_V  = 4;
   localparam logic [31:0] MODE_MASK = 32'hffffff73;
   localparam logic [31:0] VLAN_MASK = 32'h0001ffff;
   localparam logic [31:0] MACH_MASK = 32'h0000ffff;
   localparam int B_UTC_DONE  = 31;
   localparam int B_UTC_READ  = 30;
   localparam int B_SMEAR_V   = 1;
   localparam int B_CIVIL_V   = 0;
   localparam int B_OFS_OK    = 13;
   localparam int B_SHORT_P   = 12;
   localparam int B_LONG_P    = 11;
   localparam int B_SHORT_S   = 10;
   localparam int B_LONG_S    = 9;
   localparam int B_SMEAR_REQ = 8;
   localparam logic [1:0] NET_V6 = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   // ***************************************************
   // carriers
   // ***************************************************
   typedef struct packed {
      logic [7:0]   stratum;
      logic [7:0]   poll_interval;
      logic [7:0]   precision;
      logic         bcast_en;
      logic         mcast_en;
      logic         ucast_en;
      logic [1:0]   net_layer_version;
      logic         vlan_en;
      logic [15:0]  vlan_tag;
      logic [47:0]  source_mac;
      logic [127:0] source_ip;
      logic [31:0]  source_identifier;
   } server_cfg_s;
   typedef struct packed {
      logic [15:0] civil_time_offset;
      logic        civil_offset_ok;
      logic        short_minute_pending;
      logic        long_minute_pending;
      logic        smear_request;
   } civil_time_s;
endpackage

// ==== logic/ntp_server_config_regs.sv ====
`timescale 1ns/1ps
// Overview of operation
// (RULE1) read-only 32-bit count of sent broadcast packets, reset zero
// (RULE2) five commit flags in bits 4..0, set by software, cleared by device
// (RULE3) stratum in bits 31:24, precision in bits 15:8, writable, reset zero
// (RULE4) poll interval writable, taken as bits 23:16 to avoid overlap
// (RULE5) broadcast, multicast, unicast enables at bits 6, 5, 4
// (RULE6) two-bit network layer version: 1 selects v4, 2 selects v6
// (RULE7) vlan enable at bit 16, 16-bit tag in bits 15:0
// (RULE8) mac bytes 0..3 with byte 0 lowest, sent first
// (RULE9) mac bytes 4 and 5 in low half, upper half reserved
// (RULE10) primary address word: full v4 address or top of v6
// (RULE11) three more words hold v6 bytes 4..15, ignored outside v6
// (RULE12) identifier holds four ascii bytes, character 0 in top byte
// (RULE13) read bit requests snapshot, self-clears; done bit rises after capture
// (RULE14) utc control bits 1 and 0 commit smearing and civil info
// (RULE15) offset 31:16, offset ok 13, short pending 12, long pending 11
// (RULE16) read-only smearing progress bits 10 and 9
// (RULE17) info writable unless external sync; smear request writable if supported
// (RULE18) reserved bits read zero and ignore writes; all reset zero
// (RULE19) external sync takes civil info from outside, else from register
// (RULE20) 32-bit lite bus, unmapped address answers decode error
// (RULE21) self-clearing flags drop in the same cycle as their action
// (RULE22) written values reach frame logic only on commit
module ntp_server_config_regs #(
   parameter bit EXT_SYNC      = 1'b0,
   parameter bit SMEAR_SUPPORT = 1'b1,
   parameter int ADDR_W        = 16
) (
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [ADDR_W-1:0]        s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic                     broadcast_sent,
   input  wire ntp_cfg_pkg::civil_time_s ext_civil_time,
   input  wire logic                     short_minute_smearing,
   input  wire logic                     long_minute_smearing,
   output ntp_cfg_pkg::server_cfg_s      server_cfg,
   output ntp_cfg_pkg::civil_time_s      civil_time
);
   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic                     wr_rdy;
      logic                     bvalid;
      logic [1:0]               bresp;
      logic                     ar_rdy;
      logic                     rvalid;
      logic [1:0]               rresp;
      logic [31:0]              rdata;
      logic [31:0]              bcast_cnt;
      logic [4:0]               commit;
      logic [31:0]              mode;
      logic [31:0]              vlan;
      logic [31:0]              mac_lo;
      logic [31:0]              mac_hi;
      logic [127:0]             ip;
      logic [31:0]              refid;
      logic                     utc_read;
      logic                     utc_done;
      logic                     smear_commit;
      logic                     civil_commit;
      ntp_cfg_pkg::civil_time_s info;
      ntp_cfg_pkg::server_cfg_s cfg;
      ntp_cfg_pkg::civil_time_s civ;
   } state_s;

   state_s s_q;
   state_s s_d;
   logic   wr_fire;
   logic   rd_fire;

   // elaboration-time refusal; narrower buses cannot reach the civil time words
   if (ADDR_W < 9 || ADDR_W > 16)
   begin
      $error("address width must be 9 to 16 bits");
   end

   // 4-byte aligned word decode; unknown words give decode error
   function automatic logic hit(input logic [ADDR_W-1:0] a);
      logic [15:0] w;
      w = 16'(a);
      if (w[1:0] != 2'h0) return 1'b0;
      else if (w == ntp_cfg_pkg::OFS_BCAST) return 1'b1;
      else if (w >= ntp_cfg_pkg::OFS_COMMIT && w <= ntp_cfg_pkg::OFS_REFID) return 1'b1;
      else if (w == ntp_cfg_pkg::OFS_UTC_CT || w == ntp_cfg_pkg::OFS_UTC) return 1'b1;
      else return 1'b0;
   endfunction

   // read mux; reserved bits come out as zero
   function automatic logic [31:0] rd_word(input state_s s, input logic [15:0] w,
                                           input logic sh, input logic lg);
      logic [31:0] r;
      r = ntp_cfg_pkg::RESET_WORD;
      if (w == ntp_cfg_pkg::OFS_BCAST) r = s.bcast_cnt;
      else if (w == ntp_cfg_pkg::OFS_COMMIT) r = {27'h0, s.commit};
      else if (w == ntp_cfg_pkg::OFS_MODE) r = s.mode;
      else if (w == ntp_cfg_pkg::OFS_VLAN) r = s.vlan;
      else if (w == ntp_cfg_pkg::OFS_MAC_LO) r = s.mac_lo;
      else if (w == ntp_cfg_pkg::OFS_MAC_HI) r = s.mac_hi;
      else if (w == ntp_cfg_pkg::OFS_IP0) r = s.ip[31:0];
      else if (w == ntp_cfg_pkg::OFS_IP1) r = s.ip[63:32];
      else if (w == ntp_cfg_pkg::OFS_IP2) r = s.ip[95:64];
      else if (w == ntp_cfg_pkg::OFS_IP3) r = s.ip[127:96];
      else if (w == ntp_cfg_pkg::OFS_REFID) r = s.refid;
      else if (w == ntp_cfg_pkg::OFS_UTC_CT)
         r = {s.utc_done, s.utc_read, 28'h0, s.smear_commit, s.civil_commit};
      else if (w == ntp_cfg_pkg::OFS_UTC)
         r = {s.info.civil_time_offset, 2'h0, s.info.civil_offset_ok,
              s.info.short_minute_pending, s.info.long_minute_pending,
              sh, lg, s.info.smear_request, 8'h0}; // see (RULE15) see (RULE16)
      return r;
   endfunction

   // ***************************************************
   // next state
   // ***************************************************
   always_comb
   begin
      logic [15:0] wa;
      logic [31:0] wd;
      wa = 16'(s_axi_awaddr);
      wd = s_axi_wdata;
      s_d = s_q;
      wr_fire = s_q.wr_rdy && s_axi_awvalid && s_axi_wvalid;
      rd_fire = s_q.ar_rdy && s_axi_arvalid;
      // ready is a one-cycle pulse so the answer slot is never overrun
      s_d.wr_rdy = s_axi_awvalid && s_axi_wvalid && !s_q.wr_rdy && !s_q.bvalid;
      s_d.ar_rdy = s_axi_arvalid && !s_q.ar_rdy && !s_q.rvalid;
      if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
      if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
      // counter free-runs on broadcast pulses
      if (broadcast_sent) s_d.bcast_cnt = s_q.bcast_cnt + 32'h1; // see (RULE1)
      // commits: apply latched values, then drop the flag
      if (s_q.commit[ntp_cfg_pkg::B_MODE_V]) // see (RULE22)
      begin
         s_d.cfg.stratum = s_q.mode[31:24]; // see (RULE3)
         s_d.cfg.poll_interval = s_q.mode[23:16]; // see (RULE4)
         s_d.cfg.precision = s_q.mode[15:8];
         s_d.cfg.bcast_en = s_q.mode[6]; // see (RULE5)
         s_d.cfg.mcast_en = s_q.mode[5];
         s_d.cfg.ucast_en = s_q.mode[4];
         s_d.cfg.net_layer_version = s_q.mode[1:0]; // see (RULE6)
      end
      if (s_q.commit[ntp_cfg_pkg::B_VLAN_V])
      begin
         s_d.cfg.vlan_en = s_q.vlan[16]; // see (RULE7)
         s_d.cfg.vlan_tag = s_q.vlan[15:0];
      end
      if (s_q.commit[ntp_cfg_pkg::B_MAC_V])
         s_d.cfg.source_mac = {s_q.mac_hi[15:0], s_q.mac_lo}; // see (RULE8) see (RULE9)
      if (s_q.commit[ntp_cfg_pkg::B_IP_V])
      begin
         // upper words only matter for v6; zeroed otherwise
         s_d.cfg.source_ip[31:0] = s_q.ip[31:0]; // see (RULE10)
         s_d.cfg.source_ip[127:32] = (s_d.cfg.net_layer_version == ntp_cfg_pkg::NET_V6) ?
                                     s_q.ip[127:32] : 96'h0; // see (RULE11)
      end
      if (s_q.commit[ntp_cfg_pkg::B_REF_V])
         s_d.cfg.source_identifier = s_q.refid; // see (RULE12)
      s_d.commit = 5'h0; // see (RULE2) see (RULE21)
      if (s_q.civil_commit && !EXT_SYNC)
      begin
         s_d.civ.civil_time_offset = s_q.info.civil_time_offset; // see (RULE19)
         s_d.civ.civil_offset_ok = s_q.info.civil_offset_ok;
         s_d.civ.short_minute_pending = s_q.info.short_minute_pending;
         s_d.civ.long_minute_pending = s_q.info.long_minute_pending;
      end
      if (EXT_SYNC)
      begin
         s_d.civ.civil_time_offset = ext_civil_time.civil_time_offset; // see (RULE19)
         s_d.civ.civil_offset_ok = ext_civil_time.civil_offset_ok;
         s_d.civ.short_minute_pending = ext_civil_time.short_minute_pending;
         s_d.civ.long_minute_pending = ext_civil_time.long_minute_pending;
      end
      if (s_q.smear_commit && SMEAR_SUPPORT)
         s_d.civ.smear_request = s_q.info.smear_request; // see (RULE14)
      s_d.civil_commit = 1'b0;
      s_d.smear_commit = 1'b0;
      // snapshot of the civil time info in use
      if (s_q.utc_read) // see (RULE13)
      begin
         s_d.info.civil_time_offset = s_q.civ.civil_time_offset;
         s_d.info.civil_offset_ok = s_q.civ.civil_offset_ok;
         s_d.info.short_minute_pending = s_q.civ.short_minute_pending;
         s_d.info.long_minute_pending = s_q.civ.long_minute_pending;
         s_d.utc_done = 1'b1;
         s_d.utc_read = 1'b0;
      end
      // register writes come last so a set beats the self-clear
      if (wr_fire)
      begin
         s_d.bvalid = 1'b1;
         s_d.bresp = hit(s_axi_awaddr) ? ntp_cfg_pkg::RESP_OKAY :
                                         ntp_cfg_pkg::RESP_DECERR; // see (RULE20)
         if (!hit(s_axi_awaddr)) s_d.bresp = ntp_cfg_pkg::RESP_DECERR;
         else if (wa == ntp_cfg_pkg::OFS_COMMIT) s_d.commit = wd[4:0]; // see (RULE2)
         else if (wa == ntp_cfg_pkg::OFS_MODE)
            s_d.mode = wd & ntp_cfg_pkg::MODE_MASK; // see (RULE18)
         else if (wa == ntp_cfg_pkg::OFS_VLAN) s_d.vlan = wd & ntp_cfg_pkg::VLAN_MASK;
         else if (wa == ntp_cfg_pkg::OFS_MAC_LO) s_d.mac_lo = wd;
         else if (wa == ntp_cfg_pkg::OFS_MAC_HI) s_d.mac_hi = wd & ntp_cfg_pkg::MACH_MASK;
         else if (wa == ntp_cfg_pkg::OFS_IP0) s_d.ip[31:0] = wd;
         else if (wa == ntp_cfg_pkg::OFS_IP1) s_d.ip[63:32] = wd;
         else if (wa == ntp_cfg_pkg::OFS_IP2) s_d.ip[95:64] = wd;
         else if (wa == ntp_cfg_pkg::OFS_IP3) s_d.ip[127:96] = wd;
         else if (wa == ntp_cfg_pkg::OFS_REFID) s_d.refid = wd;
         else if (wa == ntp_cfg_pkg::OFS_UTC_CT)
         begin
            if (wd[ntp_cfg_pkg::B_UTC_READ])
            begin
               s_d.utc_read = 1'b1; // see (RULE13)
               s_d.utc_done = 1'b0;
            end
            s_d.smear_commit = wd[ntp_cfg_pkg::B_SMEAR_V]; // see (RULE14)
            s_d.civil_commit = wd[ntp_cfg_pkg::B_CIVIL_V];
         end
         else if (wa == ntp_cfg_pkg::OFS_UTC)
         begin
            if (!EXT_SYNC) // see (RULE17)
            begin
               s_d.info.civil_time_offset = wd[31:16];
               s_d.info.civil_offset_ok = wd[ntp_cfg_pkg::B_OFS_OK];
               s_d.info.short_minute_pending = wd[ntp_cfg_pkg::B_SHORT_P];
               s_d.info.long_minute_pending = wd[ntp_cfg_pkg::B_LONG_P];
            end
            if (SMEAR_SUPPORT) s_d.info.smear_request = wd[ntp_cfg_pkg::B_SMEAR_REQ];
         end
      end
      if (rd_fire)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = hit(s_axi_araddr) ? ntp_cfg_pkg::RESP_OKAY :
                                         ntp_cfg_pkg::RESP_DECERR; // see (RULE20)
         s_d.rdata = rd_word(s_q, 16'(s_axi_araddr), short_minute_smearing,
                             long_minute_smearing);
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst) s_q <= '0; // see (RULE18)
      else s_q <= s_d;
   end

   assign s_axi_awready = s_q.wr_rdy;
   assign s_axi_wready  = s_q.wr_rdy;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = s_q.ar_rdy;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rresp   = s_q.rresp;
   assign s_axi_rdata   = s_q.rdata;
   assign server_cfg    = s_q.cfg;
   assign civil_time    = s_q.civ;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_bcast_count_step: assert property (broadcast_sent |=> s_q.bcast_cnt ==
      $past(s_q.bcast_cnt) + 32'h1) else $error("broadcast count missed"); // see (RULE1)
   a_commit_self_clear: assert property ((s_q.commit != 5'h0) && !wr_fire |=>
      s_q.commit == 5'h0) else $error("commit flag stuck"); // see (RULE2)
   a_mode_commit_apply: assert property (s_q.commit[0] |=> server_cfg.stratum ==
      $past(s_q.mode[31:24]) && server_cfg.poll_interval == $past(s_q.mode[23:16]))
      else $error("mode not applied"); // see (RULE3)
   a_mode_held_uncommit: assert property (!s_q.commit[0] |=> $stable(server_cfg.precision)
      && $stable(server_cfg.net_layer_version)) else $error("mode moved"); // see (RULE22)
   a_vlan_commit_apply: assert property (s_q.commit[1] |=> server_cfg.vlan_en ==
      $past(s_q.vlan[16])) else $error("vlan not applied"); // see (RULE7)
   a_reserved_mode_zero: assert property (s_q.mode[7] == 1'b0 && s_q.mode[3:2] == 2'h0
      && s_q.mac_hi[31:16] == 16'h0) else $error("reserved bit set"); // see (RULE18)
   a_ipv6_upper_ignored: assert property (s_q.commit[3] && s_d.cfg.net_layer_version !=
      ntp_cfg_pkg::NET_V6 |=> server_cfg.source_ip[127:32] == 96'h0)
      else $error("v6 words leaked"); // see (RULE11)
   a_utc_read_done: assert property (s_q.utc_read |=> s_q.utc_done ##1
      (s_q.utc_done || wr_fire)) else $error("snapshot not done"); // see (RULE13)
   a_unmapped_read_err: assert property (rd_fire && !hit(s_axi_araddr) |=>
      s_axi_rvalid && s_axi_rresp == ntp_cfg_pkg::RESP_DECERR)
      else $error("no decode error"); // see (RULE20)
   a_write_answer: assert property (wr_fire |=> s_axi_bvalid && !s_axi_awready)
      else $error("no write answer"); // see (RULE20)

   c_mode_commit: cover property (wr_fire ##1 s_q.commit[0] ##1 s_q.commit == 5'h0);
   c_utc_snapshot: cover property (s_q.utc_read ##1 s_q.utc_done);
   c_decode_error: cover property (s_axi_bvalid && s_axi_bresp == ntp_cfg_pkg::RESP_DECERR);
endmodule

// ==== sim/test_ntp_server_config_regs.sv ====
`timescale 1ns/1ps
module test_ntp_server_config_regs;
   // ***************************************************
   // signals
   // ***************************************************
   logic                     mclk;
   logic                     rst;
   logic [15:0]              s_axi_awaddr;
   logic                     s_axi_awvalid;
   logic                     s_axi_awready;
   logic [31:0]              s_axi_wdata;
   logic                     s_axi_wvalid;
   logic                     s_axi_wready;
   logic [1:0]               s_axi_bresp;
   logic                     s_axi_bvalid;
   logic                     s_axi_bready;
   logic [15:0]              s_axi_araddr;
   logic                     s_axi_arvalid;
   logic                     s_axi_arready;
   logic [31:0]              s_axi_rdata;
   logic [1:0]               s_axi_rresp;
   logic                     s_axi_rvalid;
   logic                     s_axi_rready;
   logic                     broadcast_sent;
   ntp_cfg_pkg::civil_time_s ext_civil_time;
   logic                     short_minute_smearing;
   logic                     long_minute_smearing;
   ntp_cfg_pkg::server_cfg_s server_cfg;
   ntp_cfg_pkg::civil_time_s civil_time;
   ntp_cfg_pkg::civil_time_s civil_ext;
   int                       bad_count;
   int                       compares;

   ntp_server_config_regs dut_u (.mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .broadcast_sent(broadcast_sent), .ext_civil_time(ext_civil_time),
      .short_minute_smearing(short_minute_smearing),
      .long_minute_smearing(long_minute_smearing), .server_cfg(server_cfg),
      .civil_time(civil_time));

   // second copy built for external civil time; only its civil output is judged
   ntp_server_config_regs #(.EXT_SYNC(1'b1)) ext_u (.mclk(mclk), .rst(rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
      .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
      .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
      .broadcast_sent(broadcast_sent), .ext_civil_time(ext_civil_time),
      .short_minute_smearing(short_minute_smearing),
      .long_minute_smearing(long_minute_smearing), .server_cfg(),
      .civil_time(civil_ext));

   // free-running 40 MHz system clock
   always #12.5 mclk = ~mclk;

   // ***************************************************
   // checking and bus cycles
   // ***************************************************
   // wide enough for the whole configuration struct
   task automatic check(input string nm, input logic [255:0] seen, input logic [255:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic summarize();
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // bounded wait; a hung handshake ends the run as a failure
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (s !== 1'b1 && n < 40);
      if (s !== 1'b1)
      begin
         bad_count++;
         summarize();
      end
   endtask

   // address and data go up together, held until ready is sampled
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      wait_hi(s_axi_awready);
      check("wready", s_axi_wready, 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      wait_hi(s_axi_bvalid);
      check($sformatf("bresp %h", a), s_axi_bresp, er);
      @(posedge mclk);
   endtask

   // data is only judged when an okay response is expected
   task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      wait_hi(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      wait_hi(s_axi_rvalid);
      check($sformatf("rresp %h", a), s_axi_rresp, er);
      if (er === ntp_cfg_pkg::RESP_OKAY)
         check($sformatf("rdata %h", a), s_axi_rdata, ed);
      @(posedge mclk);
   endtask

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_reset();
      logic [15:0] ofs [13] = '{16'h0020, 16'h0080, 16'h0084, 16'h0088, 16'h008c, 16'h0090,
                                16'h0094, 16'h0098, 16'h009c, 16'h00a0, 16'h00a4, 16'h0100,
                                16'h0104};
      foreach (ofs[i])
         rd(ofs[i], 32'h0, 2'h0);
      check("cfg reset", 256'(server_cfg), 256'h0);
      check("civil reset", civil_time, '0);
      check("civil ext", civil_ext, 20'h5a5a4);
   endtask

   // back-to-back pulses, then a write that must not disturb the count
   task automatic t_bcast();
      repeat (5)
      begin
         broadcast_sent <= 1'b1;
         @(posedge mclk);
      end
      broadcast_sent <= 1'b0;
      @(posedge mclk);
      rd(16'h0020, 32'h5, 2'h0);
      wr(16'h0020, 32'hffffffff, 2'h0);
      rd(16'h0020, 32'h5, 2'h0);
   endtask

   task automatic t_mode();
      wr(16'h0084, 32'hffffffff, 2'h0);
      rd(16'h0084, ntp_cfg_pkg::MODE_MASK, 2'h0);
      check("mode uncommitted", server_cfg.stratum, 8'h0);
      wr(16'h0084, 32'h12345652, 2'h0);
      wr(16'h0080, 32'h1, 2'h0);
      rd(16'h0080, 32'h0, 2'h0);
      check("mode", {server_cfg.stratum, server_cfg.poll_interval, server_cfg.precision,
         server_cfg.bcast_en, server_cfg.mcast_en, server_cfg.ucast_en,
         server_cfg.net_layer_version}, {8'h12, 8'h34, 8'h56, 3'b101, 2'h2});
   endtask

   task automatic t_vlan();
      wr(16'h0088, 32'hffffffff, 2'h0);
      rd(16'h0088, ntp_cfg_pkg::VLAN_MASK, 2'h0);
      wr(16'h0080, 32'h2, 2'h0);
      check("vlan on", {server_cfg.vlan_en, server_cfg.vlan_tag}, 17'h1ffff);
      wr(16'h0088, 32'h0000abcd, 2'h0);
      wr(16'h0080, 32'h2, 2'h0);
      check("vlan off", {server_cfg.vlan_en, server_cfg.vlan_tag}, 17'h0abcd);
   endtask

   task automatic t_mac();
      wr(16'h008c, 32'h01234567, 2'h0);
      wr(16'h0090, 32'hffff89ab, 2'h0);
      rd(16'h0090, 32'h000089ab, 2'h0);
      check("mac uncommitted", server_cfg.source_mac, 48'h0);
      wr(16'h0080, 32'h4, 2'h0);
      check("mac", server_cfg.source_mac, 48'h89ab01234567);
   endtask

   // v6 keeps all four words; a v4 commit in the same cycle drops the upper ones
   task automatic t_ip();
      wr(16'h0094, 32'h11223344, 2'h0);
      wr(16'h0098, 32'h55667788, 2'h0);
      wr(16'h009c, 32'h99aabbcc, 2'h0);
      wr(16'h00a0, 32'hddeeff00, 2'h0);
      wr(16'h0080, 32'h8, 2'h0);
      check("ip v6", server_cfg.source_ip, 128'hddeeff00_99aabbcc_55667788_11223344);
      wr(16'h0084, 32'h12345621, 2'h0);
      wr(16'h0080, 32'h9, 2'h0);
      check("ip v4", server_cfg.source_ip, 128'h11223344);
      check("enables v4", {server_cfg.bcast_en, server_cfg.mcast_en,
         server_cfg.ucast_en}, 3'b010);
      check("ver v4", server_cfg.net_layer_version, 2'h1);
   endtask

   task automatic t_refid();
      wr(16'h00a4, 32'h4c4f434c, 2'h0);
      rd(16'h00a4, 32'h4c4f434c, 2'h0);
      check("refid uncommitted", server_cfg.source_identifier, 32'h0);
      wr(16'h0080, 32'h10, 2'h0);
      check("refid", server_cfg.source_identifier, 32'h4c4f434c);
   endtask

   task automatic t_utc();
      short_minute_smearing <= 1'b1;
      wr(16'h0104, 32'hffffffff, 2'h0);
      check("civil uncommitted", civil_time, 20'h0);
      wr(16'h0100, 32'h3, 2'h0);
      check("civil", civil_time, 20'hfffff);
      check("civil ext", civil_ext, 20'h5a5a5);
      // clear the info word so only the snapshot can bring the fields back
      wr(16'h0104, 32'h00000000, 2'h0);
      wr(16'h0100, 32'h40000000, 2'h0);
      rd(16'h0100, 32'h80000000, 2'h0);
      rd(16'h0104, 32'hffff3c00, 2'h0);
      short_minute_smearing <= 1'b0;
      long_minute_smearing  <= 1'b1;
      @(posedge mclk);
      rd(16'h0104, 32'hffff3a00, 2'h0);
   endtask

   task automatic t_decerr();
      rd(16'h0030, 32'h0, ntp_cfg_pkg::RESP_DECERR);
      rd(16'h0086, 32'h0, ntp_cfg_pkg::RESP_DECERR);
      wr(16'h01f0, 32'hffffffff, ntp_cfg_pkg::RESP_DECERR);
      rd(16'h0084, 32'h12345621, 2'h0);
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial
   begin
      mclk = 1'b0;
      rst = 1'b1;
      s_axi_awaddr = 16'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_araddr = 16'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b1;
      broadcast_sent = 1'b0;
      ext_civil_time = ntp_cfg_pkg::civil_time_s'(20'h5a5a5);
      short_minute_smearing = 1'b0;
      long_minute_smearing = 1'b0;
      bad_count = 0;
      compares = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_bcast();
      t_mode();
      t_vlan();
      t_mac();
      t_ip();
      t_refid();
      t_utc();
      t_decerr();
      summarize();
   end
endmodule
